//--- hdl/clkgen_ctrl.sv
// clock generator control registers, source selection and clock outputs
`timescale 1ns/1ns
// Function
// - output pin picks sub-clock, divide-by-8, divide-by-32 or undivided
// - after reset cpu runs from slow on-chip oscillator divided by eight
// - cpu source select bit resets to one, choosing on-chip oscillator
// - processor mode two bit five gates the sub-clock; one supplies it
// - pll multiply ratio comes from pll control bits two to zero
// - pll control bits five to four divide the main oscillator input
// - divider codes 00 none, 01 half, 10 quarter; 11 never written
// - clock mode one bit four stops the slow on-chip oscillator
// - clock mode one bit three disconnects the feedback resistor
// - peripheral select bit five forces undivided clock onto the pin
// - processor mode two bit four enables the non-maskable interrupt
// - slow and fast on-chip oscillators are both selectable sources
module clkgen_ctrl (
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic [clkgen_pkg::AW-1:0]  address_i,
    input  wire logic                       read_i,
    input  wire logic                       write_i,
    input  wire logic [clkgen_pkg::DW-1:0]  writedata_i,
    input  wire logic [3:0]                 byteenable_i,
    output logic      [clkgen_pkg::DW-1:0]  readdata_o,
    output logic                            waitrequest_o,
    input  wire logic                       main_osc_input_i,
    input  wire logic                       lo_osc_i,
    input  wire logic                       hi_osc_i,
    input  wire logic                       sub_osc_i,
    output logic                            cpu_clk_o,
    output logic                            clock_out_o,
    output logic                            peripheral_sub_clock_o,
    output logic                            pll_ref_clk_o,
    output logic [clkgen_pkg::PLL_N_W-1:0]  pll_multiply_o,
    output logic [1:0]                      pll_ref_div_o,
    output logic                            lo_osc_stop_o,
    output logic                            hi_osc_enable_o,
    output logic                            feedback_resistor_off_o,
    output logic                            nmi_enable_o
);
    import clkgen_pkg::*;

    typedef struct packed {
        logic [NPIN-1:0] s1;
        logic [NPIN-1:0] s2;
        logic [NPIN-1:0] s3;
        logic [BW-1:0]   cm0;
        logic [BW-1:0]   cm1;
        logic [BW-1:0]   cm2;
        logic [BW-1:0]   pclk;
        logic [BW-1:0]   pll;
        logic [BW-1:0]   pm2;
        logic [BW-1:0]   fra;
        logic [BW-1:0]   rdata;
        logic            wreq;
        logic            src_osc;
        logic            src_fast;
        cko_type         cko_src;
        logic            cko;
        logic            fc_on;
        logic            fc;
    } st_type;

    st_type          s_r;
    st_type          s_nxt;
    logic [NPIN-1:0] edge_v;
    logic            lo_lvl;
    logic            lo_tick;
    logic            hi_lvl;
    logic            hi_tick;
    logic            osc_lvl;
    logic            osc_tick;
    logic            f1_lvl;
    logic            f1_tick;
    logic            req;
    logic            wr_ok;
    logic [BW-1:0]   wd;
    logic [BW-1:0]   rd;
    cko_type         want;

    div_if cpu_if ();
    div_if ref_if ();
    div_if cko_if ();

    clk_divider cpu_div (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d       (cpu_if.div)
    );
    clk_divider ref_div (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d       (ref_if.div)
    );
    clk_divider cko_div (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d       (cko_if.div)
    );

    always_comb begin
        s_nxt = s_r;
        // two-stage synchronisers for the oscillator pins
        s_nxt.s1 = {sub_osc_i, hi_osc_i, lo_osc_i, main_osc_input_i};
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        edge_v   = s_r.s2 ^ s_r.s3;

        // on-chip oscillators, slow one stoppable
        lo_lvl  = s_r.s2[PIN_LO] && !s_r.cm1[CM1_LOSTOP];
        lo_tick = edge_v[PIN_LO] && !s_r.cm1[CM1_LOSTOP];
        hi_lvl  = s_r.s2[PIN_HI] && s_r.fra[FRA_HI_EN];
        hi_tick = edge_v[PIN_HI] && s_r.fra[FRA_HI_EN];
        osc_lvl  = s_r.src_fast ? hi_lvl : lo_lvl;
        osc_tick = s_r.src_fast ? hi_tick : lo_tick;

        // undivided clock from the selected source
        f1_lvl  = s_r.src_osc ? osc_lvl : s_r.s2[PIN_MAIN];
        f1_tick = s_r.src_osc ? osc_tick : edge_v[PIN_MAIN];

        // source change only while the cpu clock is low
        if (!cpu_if.clk) begin
            s_nxt.src_osc  = s_r.cm2[CM2_SRC];
            s_nxt.src_fast = s_r.fra[FRA_HI_SEL];
        end
        cpu_if.tick  = f1_tick;
        cpu_if.ratio = pow2_ratio(s_r.cm2[CM2_DIV_LSB +: 2]);

        // pll reference divided from the main oscillator
        ref_if.tick  = edge_v[PIN_MAIN];
        ref_if.ratio = pow2_ratio(s_r.pll[PLL_M_LSB +: 2]);

        // sub-clock gate moves only while the sub-clock is low
        if (!s_r.s2[PIN_SUB]) begin
            s_nxt.fc_on = s_r.pm2[PM2_FC];
        end
        s_nxt.fc = s_r.s2[PIN_SUB] && s_r.fc_on;

        // clock output source request
        if (s_r.pclk[PCLK_EXT]) begin
            want = SRC_F1;
        end else begin
            unique case (s_r.cm0[CKO_LSB +: 2])
                CKO_OFF: want = SRC_OFF;
                CKO_FC:  want = SRC_FC;
                CKO_F8:  want = SRC_F8;
                CKO_F32: want = SRC_F32;
            endcase
        end
        if (!s_r.cko) begin
            s_nxt.cko_src = want;
        end
        cko_if.tick = f1_tick;
        unique case (s_r.cko_src)
            SRC_F8:  cko_if.ratio = DIV_F8;
            SRC_F32: cko_if.ratio = DIV_F32;
            default: cko_if.ratio = DIV_ONE;
        endcase
        unique case (s_r.cko_src)
            SRC_OFF: s_nxt.cko = 1'b0;
            SRC_FC:  s_nxt.cko = s_r.fc;
            SRC_F8:  s_nxt.cko = cko_if.clk;
            SRC_F32: s_nxt.cko = cko_if.clk;
            SRC_F1:  s_nxt.cko = f1_lvl;
            default: s_nxt.cko = 1'b0;
        endcase

        // bus slave: one wait cycle, then the transfer completes
        req   = read_i || write_i;
        wd    = writedata_i[BW-1:0];
        wr_ok = write_i && !s_r.wreq && byteenable_i[0];
        unique case (address_i)
            IDX_CM0:  rd = s_r.cm0;
            IDX_CM1:  rd = s_r.cm1;
            IDX_CM2:  rd = {s_r.src_osc, s_r.src_fast,
                            s_r.cm2[CM2_CFG_W-1:0]};
            IDX_PCLK: rd = s_r.pclk;
            IDX_PLL:  rd = s_r.pll;
            IDX_PM2:  rd = s_r.pm2;
            IDX_FRA:  rd = s_r.fra;
            default:  rd = '0;
        endcase
        if (req && s_r.wreq) begin
            s_nxt.wreq  = 1'b0;
            s_nxt.rdata = read_i ? rd : s_r.rdata;
        end else begin
            s_nxt.wreq = 1'b1;
        end
        if (wr_ok) begin
            unique case (address_i)
                IDX_CM0:  s_nxt.cm0 = wd;
                IDX_CM1:  s_nxt.cm1 = wd;
                IDX_CM2:  s_nxt.cm2 = wd;
                IDX_PCLK: s_nxt.pclk = wd;
                IDX_PLL: begin
                    s_nxt.pll = wd;
                    // the forbidden divider code leaves the field alone
                    if (wd[PLL_M_LSB +: 2] == REFDIV_BAD) begin
                        s_nxt.pll[PLL_M_LSB +: 2] =
                            s_r.pll[PLL_M_LSB +: 2];
                    end
                end
                IDX_PM2:  s_nxt.pm2 = wd;
                IDX_FRA:  s_nxt.fra = wd;
                default: ;
            endcase
        end

        if (!rst_n_i) begin
            s_nxt          = '0;
            s_nxt.cm0      = CM0_RST;
            s_nxt.cm1      = CM1_RST;
            s_nxt.cm2      = CM2_RST;
            s_nxt.pclk     = PCLK_RST;
            s_nxt.pll      = PLL_RST;
            s_nxt.pm2      = PM2_RST;
            s_nxt.fra      = FRA_RST;
            s_nxt.wreq     = 1'b1;
            s_nxt.src_osc  = 1'b1;
            s_nxt.src_fast = 1'b0;
            s_nxt.cko_src  = SRC_OFF;
        end
    end

    always_ff @(posedge clk_i) begin
        s_r <= s_nxt;
    end

    assign readdata_o              = {{(DW-BW){1'b0}}, s_r.rdata};
    assign waitrequest_o           = s_r.wreq;
    assign cpu_clk_o               = cpu_if.clk;
    assign pll_ref_clk_o           = ref_if.clk;
    assign clock_out_o             = s_r.cko;
    assign peripheral_sub_clock_o  = s_r.fc;
    assign pll_multiply_o          = s_r.pll[PLL_N_LSB +: PLL_N_W];
    assign pll_ref_div_o           = s_r.pll[PLL_M_LSB +: 2];
    assign lo_osc_stop_o           = s_r.cm1[CM1_LOSTOP];
    assign feedback_resistor_off_o = s_r.cm1[CM1_FB];
    assign nmi_enable_o            = s_r.pm2[PM2_NMI];
    assign hi_osc_enable_o         = s_r.fra[FRA_HI_EN];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence wr_to(logic [AW-1:0] idx);
        write_i && !waitrequest_o && byteenable_i[0] && address_i == idx;
    endsequence

    sequence gate_off_low;
        !s_r.pm2[PM2_FC] && !s_r.s2[PIN_SUB];
    endsequence

    bus_answer_a: assert property (
        (read_i || write_i) && waitrequest_o |=> !waitrequest_o)
        else $error("bus request not answered after one wait cycle");
    bus_release_a: assert property (
        !waitrequest_o |=> waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    cpu_src_rst_a: assert property (
        !$past(rst_n_i) |-> s_r.cm2[CM2_SRC] && s_r.src_osc)
        else $error("cpu source select not one after reset");
    cpu_div_rst_a: assert property (
        !$past(rst_n_i) |-> cpu_if.ratio == DIV_F8 && !s_r.src_fast)
        else $error("cpu clock not slow oscillator by eight after reset");
    fc_gate_a: assert property (
        gate_off_low ##1 !s_r.pm2[PM2_FC] |=> !peripheral_sub_clock_o)
        else $error("sub-clock supplied while gate bit is zero");
    fc_follow_a: assert property (
        s_r.fc_on && s_r.s2[PIN_SUB] |=> peripheral_sub_clock_o)
        else $error("sub-clock not supplied while gate bit is one");
    pll_mult_a: assert property (
        wr_to(IDX_PLL) |=>
            pll_multiply_o == $past(writedata_i[PLL_N_LSB +: PLL_N_W]))
        else $error("pll multiply field did not take written value");
    refdiv_keep_a: assert property (
        wr_to(IDX_PLL) ##0 writedata_i[PLL_M_LSB +: 2] == REFDIV_BAD
            |=> $stable(pll_ref_div_o))
        else $error("forbidden reference divider code was stored");
    refclk_edge_a: assert property (
        $changed(pll_ref_clk_o) |-> $past(edge_v[PIN_MAIN]))
        else $error("pll reference moved without a main oscillator edge");
    lo_stop_a: assert property (
        wr_to(IDX_CM1) |=> lo_osc_stop_o == $past(writedata_i[CM1_LOSTOP]))
        else $error("slow oscillator stop bit not updated");
    lo_silent_a: assert property (
        s_r.cm1[CM1_LOSTOP] && s_r.src_osc && !s_r.src_fast |-> !f1_tick)
        else $error("stopped slow oscillator still clocks the cpu");
    fb_res_a: assert property (
        wr_to(IDX_CM1) |=>
            feedback_resistor_off_o == $past(writedata_i[CM1_FB]))
        else $error("feedback resistor bit not updated");
    cko_f1_a: assert property (
        s_r.pclk[PCLK_EXT] && !clock_out_o |=> s_r.cko_src == SRC_F1)
        else $error("extension bit did not select undivided clock");
    cko_f8_a: assert property (
        s_r.cko_src == SRC_F8 |-> cko_if.ratio == DIV_F8)
        else $error("divide-by-8 output uses wrong ratio");
    cko_f32_a: assert property (
        s_r.cko_src == SRC_F32 ##1 s_r.cko_src == SRC_F32
            |-> clock_out_o == $past(cko_if.clk))
        else $error("divide-by-32 output does not follow divider");
    nmi_en_a: assert property (
        wr_to(IDX_PM2) |=> nmi_enable_o == $past(writedata_i[PM2_NMI]))
        else $error("interrupt enable bit not updated");
    hi_sel_a: assert property (
        s_r.src_osc && s_r.src_fast |-> f1_tick == hi_tick)
        else $error("fast oscillator selected but not clocking");
    cpu_switch_a: assert property (
        $changed(s_r.src_osc) || $changed(s_r.src_fast)
            |-> !$past(cpu_clk_o))
        else $error("cpu source switched while clock high");
    cko_switch_a: assert property (
        $changed(s_r.cko_src) |-> !$past(clock_out_o))
        else $error("output source switched while pin high");
endmodule

//--- hdl/clkgen_pkg.sv
// register map, field layout and helpers for the clock generator
package clkgen_pkg;
    localparam int AW = 6;
    localparam int DW = 32;
    localparam int BW = 8;
    localparam int RW = 6;
    localparam int NPIN = 4;
    localparam int PIN_MAIN = 0;
    localparam int PIN_LO = 1;
    localparam int PIN_HI = 2;
    localparam int PIN_SUB = 3;
    localparam logic [AW-1:0] IDX_CM0  = 6'h06;
    localparam logic [AW-1:0] IDX_CM1  = 6'h07;
    localparam logic [AW-1:0] IDX_CM2  = 6'h0c;
    localparam logic [AW-1:0] IDX_PCLK = 6'h12;
    localparam logic [AW-1:0] IDX_PLL  = 6'h1c;
    localparam logic [AW-1:0] IDX_PM2  = 6'h1e;
    localparam logic [AW-1:0] IDX_FRA  = 6'h22;
    localparam logic [BW-1:0] CM0_RST  = 8'h00;
    localparam logic [BW-1:0] CM1_RST  = 8'h00;
    localparam logic [BW-1:0] CM2_RST  = 8'h0e;
    localparam logic [BW-1:0] PCLK_RST = 8'h00;
    localparam logic [BW-1:0] PLL_RST  = 8'h00;
    localparam logic [BW-1:0] PM2_RST  = 8'h00;
    localparam logic [BW-1:0] FRA_RST  = 8'h00;
    localparam int CKO_LSB = 0;
    localparam int CM1_FB = 3;
    localparam int CM1_LOSTOP = 4;
    localparam int CM2_SRC = 1;
    localparam int CM2_DIV_LSB = 2;
    localparam int CM2_CFG_W = 6;
    localparam int PCLK_EXT = 5;
    localparam int PLL_N_LSB = 0;
    localparam int PLL_N_W = 3;
    localparam int PLL_M_LSB = 4;
    localparam int PM2_NMI = 4;
    localparam int PM2_FC = 5;
    localparam int FRA_HI_EN = 0;
    localparam int FRA_HI_SEL = 1;
    localparam logic [1:0] REFDIV_BAD = 2'h3;
    localparam logic [1:0] CKO_OFF = 2'h0;
    localparam logic [1:0] CKO_FC  = 2'h1;
    localparam logic [1:0] CKO_F8  = 2'h2;
    localparam logic [1:0] CKO_F32 = 2'h3;
    localparam logic [RW-1:0] DIV_ONE = 6'h01;
    localparam logic [RW-1:0] DIV_F8  = 6'h08;
    localparam logic [RW-1:0] DIV_F32 = 6'h20;
    typedef enum logic [2:0] {
        SRC_OFF, SRC_FC, SRC_F8, SRC_F32, SRC_F1
    } cko_type;
    // power-of-two divide ratio from a two-bit code
    function automatic logic [RW-1:0] pow2_ratio(input logic [1:0] code);
        return DIV_ONE << code;
    endfunction
endpackage

//--- hdl/div_if.sv
// divider request and divided clock between generator and divider
`timescale 1ns/1ns
interface div_if;
    import clkgen_pkg::*;
    logic          tick;
    logic [RW-1:0] ratio;
    logic          clk;
    modport src (output tick, output ratio, input clk);
    modport div (input tick, input ratio, output clk);
endinterface

//--- hdl/clk_divider.sv
// edge-counting clock divider that takes a new ratio only while low
`timescale 1ns/1ns
module clk_divider (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    div_if.div        d
);
    import clkgen_pkg::*;
    typedef struct packed {
        logic [RW-1:0] cnt;
        logic [RW-1:0] ratio;
        logic          out;
    } div_st_type;
    div_st_type    s_r;
    div_st_type    s_nxt;
    logic [RW-1:0] cnt_p1;
    logic [RW-1:0] eff;
    logic          idle;
    always_comb begin
        s_nxt  = s_r;
        cnt_p1 = s_r.cnt + DIV_ONE;
        idle   = !s_r.out && s_r.cnt == '0;
        eff    = idle ? d.ratio : s_r.ratio;
        // new ratio only at the start of a low phase
        if (idle) begin
            s_nxt.ratio = d.ratio;
        end
        if (d.tick) begin
            if (cnt_p1 >= eff) begin
                s_nxt.cnt = '0;
                s_nxt.out = !s_r.out;
            end else begin
                s_nxt.cnt = cnt_p1;
            end
        end
        if (!rst_n_i) begin
            s_nxt = '0;
        end
    end
    always_ff @(posedge clk_i) begin
        s_r <= s_nxt;
    end
    assign d.clk = s_r.out;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    ratio_hold_a: assert property (
        $changed(s_r.ratio) |-> !$past(s_r.out) && $past(s_r.cnt) == '0)
        else $error("divide ratio changed inside a period");
    high_stable_a: assert property (
        s_r.out && $past(s_r.out) |-> $stable(s_r.ratio))
        else $error("divide ratio changed while clock high");
    toggle_tick_a: assert property (
        $changed(s_r.out) |-> $past(d.tick))
        else $error("divided clock moved without a source edge");
endmodule

//--- tb/mcu_clock_generator_config_tb.sv
// self-checking bench for the clock generator control block
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
    n_mismatch++; $display("BAD %s expected %0h seen %0h", nm, ex, gt); \
    end end
module mcu_clock_generator_config_tb;
    import clkgen_pkg::*;
    logic            clk_i;
    logic            rst_n_i;
    logic [AW-1:0]   address_i;
    logic            read_i;
    logic            write_i;
    logic [DW-1:0]   writedata_i;
    logic [3:0]      byteenable_i;
    logic [DW-1:0]   readdata_o;
    logic            waitrequest_o;
    logic            main_osc_input_i;
    logic            lo_osc_i;
    logic            hi_osc_i;
    logic            sub_osc_i;
    logic            cpu_clk_o;
    logic            clock_out_o;
    logic            peripheral_sub_clock_o;
    logic            pll_ref_clk_o;
    logic [2:0]      pll_multiply_o;
    logic [1:0]      pll_ref_div_o;
    logic            lo_osc_stop_o;
    logic            hi_osc_enable_o;
    logic            feedback_resistor_off_o;
    logic            nmi_enable_o;
    logic [7:0]      osc_cnt_r = 8'h00;
    int              n_mismatch;
    int              checks_done;
    int              i;
    int              p;
    logic [DW-1:0]   q;
    logic [AW-1:0]   ra[7] = '{6'h06, 6'h07, 6'h0c, 6'h12, 6'h1c, 6'h1e,
                               6'h22};
    // cm2 reads back the effective source in bit 7, on-chip after reset
    logic [7:0]      rv[7] = '{8'h00, 8'h00, 8'h8e, 8'h00, 8'h00, 8'h00,
                               8'h00};
    int              co_per[4] = '{0, 16, 64, 256};

    clkgen_ctrl clkgen_ctrl_i (
        .clk_i                   (clk_i),
        .rst_n_i                 (rst_n_i),
        .address_i               (address_i),
        .read_i                  (read_i),
        .write_i                 (write_i),
        .writedata_i             (writedata_i),
        .byteenable_i            (byteenable_i),
        .readdata_o              (readdata_o),
        .waitrequest_o           (waitrequest_o),
        .main_osc_input_i        (main_osc_input_i),
        .lo_osc_i                (lo_osc_i),
        .hi_osc_i                (hi_osc_i),
        .sub_osc_i               (sub_osc_i),
        .cpu_clk_o               (cpu_clk_o),
        .clock_out_o             (clock_out_o),
        .peripheral_sub_clock_o  (peripheral_sub_clock_o),
        .pll_ref_clk_o           (pll_ref_clk_o),
        .pll_multiply_o          (pll_multiply_o),
        .pll_ref_div_o           (pll_ref_div_o),
        .lo_osc_stop_o           (lo_osc_stop_o),
        .hi_osc_enable_o         (hi_osc_enable_o),
        .feedback_resistor_off_o (feedback_resistor_off_o),
        .nmi_enable_o            (nmi_enable_o)
    );

    // oscillator periods in system cycles: fast 2, main 4, slow 8, sub 16
    assign hi_osc_i         = osc_cnt_r[0];
    assign main_osc_input_i = osc_cnt_r[1];
    assign lo_osc_i         = osc_cnt_r[2];
    assign sub_osc_i        = osc_cnt_r[3];

    always @(posedge clk_i) begin
        osc_cnt_r <= osc_cnt_r + 8'h01;
    end

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [AW-1:0] a,
                       input logic [7:0] d, input logic [3:0] be,
                       output logic [DW-1:0] rq);
        int   n;
        logic done;
        @(posedge clk_i);
        address_i    <= a;
        writedata_i  <= {24'h000000, d};
        byteenable_i <= be;
        write_i      <= wr;
        read_i       <= ~wr;
        done = 1'b0;
        rq = '0;
        for (n = 0; n < 50 && !done; n++) begin
            @(posedge clk_i);
            done = (waitrequest_o === 1'b0);
        end
        rq = readdata_o;
        read_i  <= 1'b0;
        write_i <= 1'b0;
        if (!done) begin
            n_mismatch++;
            $display("BAD bus handshake expected 0 seen 1");
            give_verdict();
        end
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [7:0] d,
                      input logic [3:0] be = 4'h1);
        logic [DW-1:0] dummy;
        bus(1'b1, a, d, be, dummy);
        @(negedge clk_i);
    endtask

    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] rq);
        bus(1'b0, a, 8'h00, 4'h1, rq);
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return cpu_clk_o;
            1: return clock_out_o;
            2: return peripheral_sub_clock_o;
            default: return pll_ref_clk_o;
        endcase
    endfunction

    // period between 2nd and 3rd rising edge; 0 when the clock stands
    task automatic measure(input int w, output int per);
        int   n;
        int   rises;
        int   t0;
        logic prev;
        per = 0;
        rises = 0;
        t0 = 0;
        prev = pick(w);
        for (n = 0; n < 1200 && rises < 3; n++) begin
            @(negedge clk_i);
            if (pick(w) === 1'b1 && prev === 1'b0) begin
                rises++;
                if (rises == 2) t0 = n;
                if (rises == 3) per = n - t0;
            end
            prev = pick(w);
        end
    endtask

    initial begin
        rst_n_i      = 1'b0;
        read_i       = 1'b0;
        write_i      = 1'b0;
        address_i    = '0;
        writedata_i  = '0;
        byteenable_i = 4'h1;
        n_mismatch   = 0;
        checks_done  = 0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 7; i++) begin
            rd(ra[i], q);
            `CHK("reset value", {24'h000000, rv[i]}, q)
        end
        measure(0, p);
        `CHK("cpu period after reset", 64, p)
        measure(2, p);
        `CHK("sub clock after reset", 0, p)
        `CHK("fast osc enable", 1'b0, hi_osc_enable_o)
        wr(6'h3f, 8'hff);
        rd(6'h3f, q);
        `CHK("unmapped read", 32'h00000000, q)
        wr(IDX_CM1, 8'h18, 4'he);
        rd(IDX_CM1, q);
        `CHK("masked write", 32'h00000000, q)
        wr(IDX_CM1, 8'h18);
        `CHK("slow osc stop", 1'b1, lo_osc_stop_o)
        `CHK("feedback off", 1'b1, feedback_resistor_off_o)
        wr(IDX_CM1, 8'h08);
        `CHK("slow osc stop", 1'b0, lo_osc_stop_o)
        `CHK("feedback off", 1'b1, feedback_resistor_off_o)
        wr(IDX_PM2, 8'h30);
        `CHK("nmi enable", 1'b1, nmi_enable_o)
        measure(2, p);
        `CHK("sub clock period", 16, p)
        wr(IDX_PM2, 8'h10);
        measure(2, p);
        `CHK("sub clock gated", 0, p)
        wr(IDX_PM2, 8'h20);
        `CHK("nmi enable", 1'b0, nmi_enable_o)
        for (i = 0; i < 3; i++) begin
            wr(IDX_PLL, 8'(i * 16 + i + 5));
            `CHK("pll multiply", 3'(i + 5), pll_multiply_o)
            `CHK("pll ref div", 2'(i), pll_ref_div_o)
            measure(3, p);
            `CHK("pll ref period", 4 << i, p)
        end
        wr(IDX_PLL, 8'h33);
        rd(IDX_PLL, q);
        `CHK("pll forbidden code", 32'h00000023, q)
        `CHK("pll multiply", 3'h3, pll_multiply_o)
        measure(3, p);
        `CHK("pll ref period", 16, p)
        for (i = 0; i < 4; i++) begin
            wr(IDX_CM0, 8'(i));
            measure(1, p);
            `CHK("clock out period", co_per[i], p)
        end
        wr(IDX_PCLK, 8'h20);
        measure(1, p);
        `CHK("clock out undivided", 8, p)
        wr(IDX_PCLK, 8'h00);
        measure(1, p);
        `CHK("clock out div32", 256, p)
        wr(IDX_FRA, 8'h03);
        `CHK("fast osc enable", 1'b1, hi_osc_enable_o)
        wr(IDX_CM2, 8'h02);
        measure(0, p);
        `CHK("cpu fast period", 2, p)
        rd(IDX_CM2, q);
        `CHK("cpu source status", 32'h000000c2, q)
        wr(IDX_FRA, 8'h01);
        measure(0, p);
        `CHK("cpu slow period", 8, p)
        rd(IDX_CM2, q);
        `CHK("cpu source status", 32'h00000082, q)
        for (i = 0; i < 4; i++) begin
            wr(IDX_CM2, 8'(i << 2));
            measure(0, p);
            `CHK("cpu main period", 4 << i, p)
        end
        give_verdict();
    end
endmodule
